// file: lcdp_dev.sv
`timescale 1ns/1ps
module lcdp_dev
  import lcdp_pkg::*;
#(
  parameter logic [7:0] EXEC_OSC = 8'(EXEC_OSC_DEF),
  parameter int         SCAN_N   = SCAN_CLKS,
  parameter int         COM_N    = COM_COUNT
)(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  lcdp_if.dev             port,
  input  wire logic [7:0] ram_rd_data_in,
  output logic [7:0]      instr_out,
  output logic            instr_valid_out,
  output logic [7:0]      wr_data_out,
  output logic            wr_valid_out,
  output logic            rd_ack_out,
  output logic [6:0]      addr_counter_out,
  output logic            busy_out,
  output logic            width8_out,
  output logic [4:0]      com_index_out,
  output logic            frame_start_out,
  output logic            osc_tick_out
);
  typedef struct packed {
    logic       e_prev;
    logic       width8;
    logic       phase;
    logic [3:0] hi_nib;
    logic       busy;
    logic [7:0] exec_cnt;
    logic [6:0] ac;
    logic [7:0] rd_byte;
    logic [7:0] db;
    logic       oe;
    logic [11:0] div;
    logic [5:0] scan;
    logic [4:0] com;
    logic       frame;
    logic       osc_tick;
    logic [7:0] ir;
    logic       ir_vld;
    logic [7:0] wdat;
    logic       wr_vld;
    logic       rd_vld;
  } lcdp_dev_st_t;

  localparam lcdp_dev_st_t ST_RST = '{width8: WIDTH8_RST, default: '0};
  localparam logic [11:0] DIV_LAST  = 12'(OSC_DIV - 1);
  localparam logic [5:0]  SCAN_LAST = 6'(SCAN_N - 1);
  localparam logic [4:0]  COM_LAST  = 5'(COM_N - 1);

  lcdp_dev_st_t q_ff;
  lcdp_dev_st_t nxt_q;

  // next-state for port, busy timer and frame timing
  always_comb
  begin
    logic       osc_now;
    logic       rise;
    logic       full;
    logic [7:0] byte_v;
    logic [7:0] snap;
    osc_now = (q_ff.div == DIV_LAST);
    rise    = port.e & ~q_ff.e_prev;
    full    = 1'b0;
    byte_v  = 8'h00;
    snap    = 8'h00;
    nxt_q = q_ff;
    nxt_q.e_prev   = port.e;
    nxt_q.ir_vld   = 1'b0;
    nxt_q.wr_vld   = 1'b0;
    nxt_q.rd_vld   = 1'b0;
    nxt_q.frame    = 1'b0;
    nxt_q.osc_tick = osc_now;

    if (osc_now)
    begin
      nxt_q.div = 12'h000;
    end
    else
    begin
      nxt_q.div = q_ff.div + 12'h001;
    end

    if (osc_now)
    begin
      if (q_ff.scan == SCAN_LAST)
      begin
        nxt_q.scan = 6'h00;
        if (q_ff.com == COM_LAST)
        begin
          nxt_q.com   = 5'h00;
          nxt_q.frame = 1'b1;
        end
        else
        begin
          nxt_q.com = q_ff.com + 5'h01;
        end
      end
      else
      begin
        nxt_q.scan = q_ff.scan + 6'h01;
      end
    end

    // busy clears when execution time ends
    if (q_ff.busy && osc_now)
    begin
      if (q_ff.exec_cnt == 8'h00)
      begin
        nxt_q.busy = 1'b0;
      end
      else
      begin
        nxt_q.exec_cnt = q_ff.exec_cnt - 8'h01;
      end
    end

    // read data driven while a read strobe is high, one clock late
    nxt_q.oe = port.e & port.rw;

    if (rise && !port.rw)
    begin
      // one or two transfers per access
      if (q_ff.width8)
      begin
        full   = 1'b1;
        byte_v = port.db;
      end
      // high nibble then low on db[7:4]
      else if (q_ff.phase == PHASE_HI)
      begin
        nxt_q.hi_nib = port.db[7:4];
        nxt_q.phase  = ~PHASE_HI;
      end
      else
      begin
        full        = 1'b1;
        byte_v      = {q_ff.hi_nib, port.db[7:4]};
        nxt_q.phase = PHASE_HI;
      end
    end

    if (full)
    begin
      // busy set on complete latch; wins over clear
      nxt_q.busy     = 1'b1;
      nxt_q.exec_cnt = EXEC_OSC;
      if (port.register_select)
      begin
        nxt_q.wdat   = byte_v;
        nxt_q.wr_vld = 1'b1;
        nxt_q.ac     = q_ff.ac + 7'h01;
      end
      else
      begin
        nxt_q.ir     = byte_v;
        nxt_q.ir_vld = 1'b1;
        if (byte_v[SET_DD_BIT])
        begin
          nxt_q.ac = byte_v[6:0];
        end
        else if (byte_v[FUNC_SET_BIT])
        begin
          nxt_q.width8 = byte_v[FUNC_DL_BIT];
          // width change restarts at high nibble
          if (byte_v[FUNC_DL_BIT] != q_ff.width8)
          begin
            nxt_q.phase = PHASE_HI;
          end
        end
      end
    end

    if (rise && port.rw)
    begin
      snap = port.register_select ? ram_rd_data_in : {q_ff.busy, q_ff.ac};
      if (q_ff.width8)
      begin
        nxt_q.db = snap;
      end
      // status and data come back as two nibbles
      else if (q_ff.phase == PHASE_HI)
      begin
        nxt_q.rd_byte = snap;
        nxt_q.db      = {snap[7:4], 4'h0};
        nxt_q.phase   = ~PHASE_HI;
      end
      else
      begin
        nxt_q.db    = {q_ff.rd_byte[3:0], 4'h0};
        nxt_q.phase = PHASE_HI;
      end
      // data read completes on the last transfer only
      if (port.register_select &&
          (q_ff.width8 || q_ff.phase != PHASE_HI))
      begin
        nxt_q.rd_vld = 1'b1;
        nxt_q.ac     = q_ff.ac + 7'h01;
      end
    end

    // reset pin restores 8-bit width and high phase
    if (!port.hw_rst_n)
    begin
      nxt_q = ST_RST;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q_ff <= ST_RST;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from the state register
  assign port.db_dev      = q_ff.db;
  assign port.db_dev_oe   = q_ff.oe;
  assign instr_out        = q_ff.ir;
  assign instr_valid_out  = q_ff.ir_vld;
  assign wr_data_out      = q_ff.wdat;
  assign wr_valid_out     = q_ff.wr_vld;
  assign rd_ack_out       = q_ff.rd_vld;
  assign addr_counter_out = q_ff.ac;
  assign busy_out         = q_ff.busy;
  assign width8_out       = q_ff.width8;
  assign com_index_out    = q_ff.com;
  assign frame_start_out  = q_ff.frame;
  assign osc_tick_out     = q_ff.osc_tick;
endmodule

// file: lcdp_pkg.sv
// Function
// - display timing from internal 80 kHz clock
// - frame is 18 scans of 60 clocks
// - one 8-bit or two 4-bit transfers
// - 4-bit data on upper lines only
// - high nibble first, pair is one access
// - host polls busy only after pairs
// - 4-bit status read takes two nibbles
// - host holds reset low 1.2 ms
// - host initializes by instructions if needed
// - width defaults to 8-bit after reset
// - busy unreliable until final width set
package lcdp_pkg;
  // system clock
  localparam int CLK_HZ         = 250_000_000;
  localparam int CLK_PERIOD_NS  = 4;
  // timing oscillator and frame structure
  localparam int OSC_HZ         = 80_000;
  localparam int OSC_PERIOD_NS  = 12_500;
  localparam int OSC_DIV        = CLK_HZ / OSC_HZ;
  localparam int SCAN_CLKS      = 60;
  localparam int COM_COUNT      = 18;
  localparam int FRAME_CLKS     = SCAN_CLKS * COM_COUNT;
  // strobe timing seen by the host end
  localparam int E_HIGH_NS      = 600;
  localparam int E_CYCLE_NS     = 1_000;
  localparam int E_HIGH_CYC     =
    (E_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int E_LOW_CYC      =
    (E_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - E_HIGH_CYC;
  // hardware reset low width
  localparam int RST_HOLD_NS    = 1_200_000;
  localparam int RST_HOLD_CYC   =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_CNT_W     = 19;
  // instruction fields
  localparam int SET_DD_BIT     = 7;
  localparam int FUNC_SET_BIT   = 5;
  localparam int FUNC_DL_BIT    = 4;
  localparam int EXEC_OSC_DEF   = 4;
  // reset values
  localparam logic WIDTH8_RST   = 1'b1;
  localparam logic PHASE_HI     = 1'b0;
  localparam logic [7:0] DB_PULLUP = 8'hff;
endpackage

// file: lcdp_if.sv
`timescale 1ns/1ps
interface lcdp_if;
  import lcdp_pkg::*;
  logic       register_select;
  logic       rw;
  logic       e;
  logic       hw_rst_n;
  logic [7:0] db_host;
  logic       db_host_oe;
  logic [7:0] db_dev;
  logic       db_dev_oe;
  logic [7:0] db;

  // resolved bus; pull-ups hold undriven lines high
  assign db = db_host_oe ? db_host : (db_dev_oe ? db_dev : DB_PULLUP);

  modport dev (
    input  register_select,
    input  rw,
    input  e,
    input  hw_rst_n,
    input  db,
    output db_dev,
    output db_dev_oe
  );
  modport host (
    output register_select,
    output rw,
    output e,
    output hw_rst_n,
    output db_host,
    output db_host_oe,
    input  db
  );
endinterface

// file: lcdp_host.sv
`timescale 1ns/1ps
module lcdp_host
  import lcdp_pkg::*;
#(
  parameter int RESET_CYC = RST_HOLD_CYC,
  parameter int E_HI      = E_HIGH_CYC,
  parameter int E_LO      = E_LOW_CYC
)(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  lcdp_if.host            port,
  input  wire logic       rst_req_in,
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_rs_in,
  input  wire logic       cmd_rw_in,
  input  wire logic [7:0] cmd_data_in,
  output logic            cmd_ready_out,
  output logic            done_out,
  output logic [7:0]      rsp_data_out,
  output logic            width8_out
);
  typedef enum logic [1:0] {H_IDLE, H_RST, H_HI, H_LO} lcdp_hst_t;

  typedef struct packed {
    lcdp_hst_t             state;
    logic [HOST_CNT_W-1:0] cnt;
    logic                  second;
    logic                  rs;
    logic                  rw;
    logic [7:0]            data;
    logic                  width8;
    logic [3:0]            hi_rd;
    logic [7:0]            rsp;
    logic                  done;
    logic                  e;
    logic                  rst_n;
    logic [7:0]            dbo;
    logic                  dboe;
    logic                  ready;
  } lcdp_host_st_t;

  localparam lcdp_host_st_t ST_RST =
    '{state: H_IDLE, width8: WIDTH8_RST, rst_n: 1'b1, ready: 1'b1,
      default: '0};
  localparam logic [HOST_CNT_W-1:0] HI_LAST  = HOST_CNT_W'(E_HI - 1);
  localparam logic [HOST_CNT_W-1:0] LO_LAST  = HOST_CNT_W'(E_LO - 1);
  localparam logic [HOST_CNT_W-1:0] RST_LAST = HOST_CNT_W'(RESET_CYC - 1);
  localparam logic [HOST_CNT_W-1:0] CNT_ONE  = HOST_CNT_W'(1);

  lcdp_host_st_t q_ff;
  lcdp_host_st_t nxt_q;

  // access sequencer
  always_comb
  begin
    nxt_q      = q_ff;
    nxt_q.done = 1'b0;
    case (q_ff.state)
      H_IDLE:
      begin
        // hold the reset pin low for the full width
        if (rst_req_in)
        begin
          nxt_q.state  = H_RST;
          nxt_q.cnt    = RST_LAST;
          nxt_q.rst_n  = 1'b0;
          nxt_q.width8 = WIDTH8_RST;
        end
        else if (cmd_valid_in)
        begin
          nxt_q.rs     = cmd_rs_in;
          nxt_q.rw     = cmd_rw_in;
          nxt_q.data   = cmd_data_in;
          nxt_q.e      = 1'b1;
          nxt_q.dboe   = ~cmd_rw_in;
          // width follows what the device was told
          nxt_q.second = ~q_ff.width8;
          // high nibble goes first on db[7:4]
          nxt_q.dbo    = q_ff.width8 ? cmd_data_in
                                     : {cmd_data_in[7:4], 4'h0};
          nxt_q.cnt    = HI_LAST;
          nxt_q.state  = H_HI;
        end
      end
      H_RST:
      begin
        if (q_ff.cnt == '0)
        begin
          nxt_q.rst_n = 1'b1;
          nxt_q.state = H_IDLE;
        end
        else
        begin
          nxt_q.cnt = q_ff.cnt - CNT_ONE;
        end
      end
      H_HI:
      begin
        if (q_ff.cnt == '0)
        begin
          nxt_q.e   = 1'b0;
          nxt_q.cnt = LO_LAST;
          nxt_q.state = H_LO;
          // collect a read as one byte, or as high then low nibble
          if (q_ff.rw)
          begin
            if (q_ff.width8)
            begin
              nxt_q.rsp = port.db;
            end
            else if (q_ff.second)
            begin
              nxt_q.hi_rd = port.db[7:4];
            end
            else
            begin
              nxt_q.rsp = {q_ff.hi_rd, port.db[7:4]};
            end
          end
        end
        else
        begin
          nxt_q.cnt = q_ff.cnt - CNT_ONE;
        end
      end
      H_LO:
      begin
        if (q_ff.cnt != '0)
        begin
          nxt_q.cnt = q_ff.cnt - CNT_ONE;
        end
        // low nibble follows at once, no poll between
        else if (q_ff.second)
        begin
          nxt_q.second = 1'b0;
          nxt_q.e      = 1'b1;
          nxt_q.dbo    = {q_ff.data[3:0], 4'h0};
          nxt_q.cnt    = HI_LAST;
          nxt_q.state  = H_HI;
        end
        else
        begin
          nxt_q.done  = 1'b1;
          nxt_q.dboe  = 1'b0;
          nxt_q.state = H_IDLE;
          // new width takes effect after the function set ends;
          // decode mirrors the device so both ends switch on the same instruction
          if (!q_ff.rs && !q_ff.rw && !q_ff.data[SET_DD_BIT] &&
              q_ff.data[FUNC_SET_BIT])
          begin
            nxt_q.width8 = q_ff.data[FUNC_DL_BIT];
          end
        end
      end
      default:
      begin
        nxt_q = ST_RST;
      end
    endcase
    nxt_q.ready = (nxt_q.state == H_IDLE);
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q_ff <= ST_RST;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // pins and user outputs from the state register
  assign port.register_select = q_ff.rs;
  assign port.rw              = q_ff.rw;
  assign port.e               = q_ff.e;
  assign port.hw_rst_n        = q_ff.rst_n;
  assign port.db_host         = q_ff.dbo;
  assign port.db_host_oe      = q_ff.dboe;
  assign cmd_ready_out        = q_ff.ready;
  assign done_out             = q_ff.done;
  assign rsp_data_out         = q_ff.rsp;
  assign width8_out           = q_ff.width8;
endmodule

// file: lcdp_props.sv
`timescale 1ns/1ps
module lcdp_props
  import lcdp_pkg::*;
#(
  parameter int E_HI      = E_HIGH_CYC,
  parameter int E_LO      = E_LOW_CYC,
  parameter int RESET_CYC = RST_HOLD_CYC
)(
  input wire logic       clk_in,
  input wire logic       arst_n_in,
  input wire logic       register_select,
  input wire logic       rw,
  input wire logic       e,
  input wire logic       hw_rst_n,
  input wire logic [7:0] db_host,
  input wire logic       db_host_oe,
  input wire logic [7:0] db_dev,
  input wire logic       db_dev_oe
);
  int e_hi_cnt;
  int e_lo_cnt;
  int rst_cnt;

  // width counters; low count starts saturated so the first strobe
  // after reset is not mistaken for a short gap
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      e_hi_cnt <= 0;
      e_lo_cnt <= 255;
      rst_cnt  <= 0;
    end
    else
    begin
      e_hi_cnt <= e ? e_hi_cnt + 1 : 0;
      e_lo_cnt <= e ? 0 : (e_lo_cnt < 255 ? e_lo_cnt + 1 : 255);
      rst_cnt  <= hw_rst_n ? 0 : rst_cnt + 1;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // read strobe start and strobe end
  sequence s_rd_start;
    $rose(e) && rw;
  endsequence
  sequence s_strobe_end;
    $fell(e);
  endsequence

  a_e_high_len: assert property (s_strobe_end |-> e_hi_cnt == E_HI)
    else $error("strobe high width wrong");
  a_e_low_gap: assert property ($rose(e) |-> e_lo_cnt >= E_LO)
    else $error("strobe low gap too short");
  a_rd_answer: assert property (s_rd_start |=> db_dev_oe && !db_host_oe)
    else $error("read not answered");
  a_oe_cause: assert property (db_dev_oe |-> $past(e) && $past(rw))
    else $error("device drove bus outside a read");
  a_no_contend: assert property (!(db_host_oe && db_dev_oe))
    else $error("both ends drive the bus");
  a_wr_drive: assert property (e && !rw |-> db_host_oe)
    else $error("write strobe without data");
  a_oe_dir: assert property (db_host_oe |-> !rw)
    else $error("host drove bus during a read");
  a_ctl_stable: assert property (e && $past(e) |->
    $stable(register_select) && $stable(rw) && $stable(db_host))
    else $error("control changed while strobe high");
  a_rst_hold: assert property ($rose(hw_rst_n) |-> rst_cnt >= RESET_CYC)
    else $error("reset pulse too short");
  a_rst_quiet: assert property (!hw_rst_n |-> !e && !db_host_oe)
    else $error("host active during reset pulse");
endmodule

// file: lcd_mpu_port_frame_timing_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) \
  begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (b)); end end
module lcd_mpu_port_frame_timing_bench;
  import lcdp_pkg::*;
  localparam int T_LIMIT = 80_000;
  localparam int RST_SIM = 20;
  localparam int EHI_SIM = 3;
  localparam int ELO_SIM = 2;
  localparam int EXE_SIM = 1;
  localparam int SCN_SIM = 2;
  localparam int COM_SIM = 3;
  // selectors of the levels that wait_sig can watch
  localparam int W_RDY   = 0;
  localparam int W_DONE  = 1;
  localparam int W_BUSY  = 2;
  localparam int W_TICK  = 3;
  localparam int W_FRM   = 4;
  logic       clk_in    = 1'b0;
  logic       arst_n_in = 1'b0;
  logic       rst_req   = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_rs    = 1'b0;
  logic       cmd_rw    = 1'b0;
  logic [7:0] cmd_data  = 8'h00;
  logic [7:0] ram_rd    = 8'h5a;
  logic       cmd_ready, done_p, h_w8, d_w8, busy, tick;
  logic [7:0] rsp, instr, wr_data, q;
  logic [6:0] ac;
  logic [4:0] com;
  logic       ir_v, wr_v, rd_v, frm;
  int         err_count = 0;
  int         checks    = 0;
  int         cyc       = 0;
  int         n;
  int         n_ir      = 0;
  int         n_wr      = 0;
  int         n_rd      = 0;

  lcdp_if bus ();
  lcdp_host #(.RESET_CYC(RST_SIM), .E_HI(EHI_SIM), .E_LO(ELO_SIM))
  i_lcdp_host (.clk_in(clk_in), .arst_n_in(arst_n_in), .port(bus),
    .rst_req_in(rst_req), .cmd_valid_in(cmd_valid), .cmd_rs_in(cmd_rs),
    .cmd_rw_in(cmd_rw), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
    .done_out(done_p), .rsp_data_out(rsp), .width8_out(h_w8));
  lcdp_dev #(.EXEC_OSC(8'(EXE_SIM)), .SCAN_N(SCN_SIM), .COM_N(COM_SIM))
  i_lcdp_dev (.clk_in(clk_in), .arst_n_in(arst_n_in), .port(bus),
    .ram_rd_data_in(ram_rd), .instr_out(instr), .instr_valid_out(ir_v),
    .wr_data_out(wr_data), .wr_valid_out(wr_v), .rd_ack_out(rd_v),
    .addr_counter_out(ac), .busy_out(busy), .width8_out(d_w8),
    .com_index_out(com), .frame_start_out(frm), .osc_tick_out(tick));

  // one-cycle completion pulses, counted so pairing can be checked
  always @(negedge clk_in)
  begin
    if (ir_v)
      n_ir++;
    if (wr_v)
      n_wr++;
    if (rd_v)
      n_rd++;
  end
  lcdp_props #(.E_HI(EHI_SIM), .E_LO(ELO_SIM), .RESET_CYC(RST_SIM))
  i_lcdp_props (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .register_select(bus.register_select), .rw(bus.rw), .e(bus.e),
    .hw_rst_n(bus.hw_rst_n), .db_host(bus.db_host),
    .db_host_oe(bus.db_host_oe), .db_dev(bus.db_dev),
    .db_dev_oe(bus.db_dev_oe));

  // clock and hang guard
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == T_LIMIT)
    begin
      err_count++;
      end_sim();
    end
  end

  task end_sim();
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // level of one watched output, picked by selector
  function automatic logic pick(input int sel);
    case (sel)
      W_RDY:   pick = cmd_ready;
      W_DONE:  pick = done_p;
      W_BUSY:  pick = busy;
      W_TICK:  pick = tick;
      default: pick = frm;
    endcase
  endfunction

  // bounded wait on a level, counting falling edges in n
  task automatic wait_sig(input int sel, input logic v, input int lim);
    begin
      n = 0;
      while (pick(sel) !== v && n < lim)
      begin
        @(negedge clk_in);
        n++;
      end
      `CHK(n < lim, 1'b1)
    end
  endtask

  // one host access; request held until the take edge has passed
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d);
    begin
      wait_sig(W_RDY, 1'b1, 300);
      cmd_valid = 1'b1;
      cmd_rs    = rs;
      cmd_rw    = rw;
      cmd_data  = d;
      @(negedge clk_in);
      cmd_valid = 1'b0;
      wait_sig(W_DONE, 1'b1, 100);
      q = rsp;
    end
  endtask

  // reset, 8-bit, 4-bit, oscillator, frame, hardware reset
  initial
  begin
    repeat (10) @(negedge clk_in);
    arst_n_in = 1'b1;
    @(negedge clk_in);
    `CHK(d_w8, 1'b1)
    `CHK(h_w8, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(ac, 7'h00)
    $display("test reset done");
    acc(1'b0, 1'b0, 8'h85);
    `CHK(instr, 8'h85)
    `CHK(ac, 7'h05)
    `CHK(busy, 1'b1)
    acc(1'b0, 1'b1, 8'h00);
    `CHK(q, 8'h85)
    wait_sig(W_BUSY, 1'b0, 20000);
    `CHK(n + 16 >= OSC_DIV * EXE_SIM, 1'b1)
    `CHK(n <= OSC_DIV * (EXE_SIM + 1), 1'b1)
    acc(1'b1, 1'b0, 8'ha5);
    `CHK(wr_data, 8'ha5)
    `CHK(ac, 7'h06)
    $display("test 8bit done");
    acc(1'b0, 1'b0, 8'h20);
    `CHK(d_w8, 1'b0)
    `CHK(h_w8, 1'b0)
    acc(1'b1, 1'b0, 8'h3c);
    `CHK(wr_data, 8'h3c)
    `CHK(ac, 7'h07)
    acc(1'b0, 1'b1, 8'h00);
    `CHK(q, 8'h87)
    acc(1'b1, 1'b1, 8'h00);
    `CHK(q, 8'h5a)
    `CHK(ac, 7'h08)
    $display("test 4bit done");
    wait_sig(W_TICK, 1'b1, 5000);
    @(negedge clk_in);
    wait_sig(W_TICK, 1'b1, 5000);
    `CHK(n + 1, OSC_DIV)
    $display("test osc done");
    // shortened frame: scan and common counts cut for run time
    wait_sig(W_FRM, 1'b1, 20000);
    `CHK(com, 5'h00)
    @(negedge clk_in);
    wait_sig(W_FRM, 1'b1, 20000);
    `CHK(n + 1, OSC_DIV * SCN_SIM * COM_SIM)
    $display("test frame done");
    rst_req = 1'b1;
    @(negedge clk_in);
    rst_req = 1'b0;
    @(negedge clk_in);
    wait_sig(W_RDY, 1'b1, 200);
    `CHK(d_w8, 1'b1)
    `CHK(h_w8, 1'b1)
    `CHK(ac, 7'h00)
    `CHK(busy, 1'b0)
    acc(1'b0, 1'b0, 8'h83);
    `CHK(instr, 8'h83)
    `CHK(ac, 7'h03)
    `CHK(n_ir, 3)
    `CHK(n_wr, 2)
    `CHK(n_rd, 1)
    $display("test hwreset done");
    end_sim();
  end
endmodule
